/* File: src/wdc_prescale_control.v */
`timescale 1ns/1ns
`default_nettype none
`include "wdc_regs.vh"

// ************************************************************
// Watchdog prescale control register and interval counter
// ************************************************************
module wdc_prescale_control #(
   parameter CNT_W = 24
) (
   // Clock and reset
   input  wire             mclk_i,
   input  wire             reset_i,
   // Configuration word
   input  wire [4:0]       config_prescale_default_i,
   input  wire [1:0]       config_enable_mode_i,
   input  wire             sleep_i,
   // Watchdog clear
   input  wire             wdt_clear_i,
   // Register port
   input  wire [3:0]       addr_i,
   input  wire [7:0]       wdata_i,
   input  wire             wr_i,
   input  wire             rd_i,
   output reg  [7:0]       rdata_o,
   // Status
   output reg              wdt_running_o,
   output reg              wdt_timeout_o,
   output reg  [4:0]       prescale_select_o
);

   // ************************************************************
   // Helpers
   // ************************************************************
   // Reserved codes fold to the shortest ratio
   function [4:0] eff_log2;
      input [4:0] code;
      begin
         if (code > `WDC_PS_MAX_CODE) begin
            eff_log2 = `WDC_PS_BASE_LOG2;
         end else begin
            eff_log2 = code + `WDC_PS_BASE_LOG2;
         end
      end
   endfunction

   // Last count of one interval, ratio minus one
   function [CNT_W-1:0] last_count;
      input [4:0] code;
      reg   [CNT_W-1:0] one;
      begin
         one        = {{(CNT_W-1){1'b0}}, 1'b1};
         last_count = (one << eff_log2(code)) - one;
      end
   endfunction

   // Address match, shared by write and read paths
   function addr_hit;
      input [3:0] addr;
      input [3:0] target;
      begin
         addr_hit = (addr == target);
      end
   endfunction

   // ************************************************************
   // Declarations
   // ************************************************************
   reg  [4:0]       prescale_select;
   reg  [4:0]       next_prescale_select;
   reg              soft_enable;
   reg              next_soft_enable;
   reg  [CNT_W-1:0] count;
   reg  [CNT_W-1:0] next_count;
   reg              next_timeout;
   reg  [7:0]       next_rdata;
   reg              run;
   wire             ctrl_write;
   wire             ctrl_read;
   wire             count_read;
   wire             ps_writable;
   wire             restart;
   wire             at_last;

   assign ctrl_write  = wr_i && addr_hit(addr_i, `WDC_CTRL_ZERO_ADDR);
   assign ctrl_read   = rd_i && addr_hit(addr_i, `WDC_CTRL_ZERO_ADDR);
   assign count_read  = rd_i && addr_hit(addr_i, `WDC_COUNT_ADDR);
   // Field is writable only with an all-ones default
   assign ps_writable = (config_prescale_default_i == `WDC_PS_ALL_ONES);

   // ************************************************************
   // Enable mode decode
   // ************************************************************
   // Sleep-off mode stops the count while asleep
   always @* begin
      run = 1'b0;
      case (config_enable_mode_i)
         `WDC_MODE_OFF: begin
            run = 1'b0;
         end
         `WDC_MODE_SOFT: begin
            run = soft_enable;
         end
         `WDC_MODE_SLEEP_OFF: begin
            run = !sleep_i;
         end
         `WDC_MODE_ON: begin
            run = 1'b1;
         end
         default: begin
            run = 1'b0;
         end
      endcase
   end

   // ************************************************************
   // Control register
   // ************************************************************
   always @* begin
      next_prescale_select = prescale_select;
      next_soft_enable     = soft_enable;
      if (reset_i) begin
         if (ps_writable) begin
            next_prescale_select = `WDC_PS_FORCED_RST;
         end else begin
            next_prescale_select = config_prescale_default_i;
         end
         next_soft_enable = `WDC_SOFT_EN_RST;
      end else if (ctrl_write) begin
         next_soft_enable = wdata_i[`WDC_SOFT_EN_BIT];
         // Locked field keeps its configured value
         if (ps_writable) begin
            next_prescale_select = wdata_i[`WDC_PS_MSB:`WDC_PS_LSB];
         end
      end
   end

   always @(posedge mclk_i) begin
      prescale_select <= next_prescale_select;
   end

   always @(posedge mclk_i) begin
      soft_enable <= next_soft_enable;
   end

   // ************************************************************
   // Interval counter
   // ************************************************************
   // Width covers the longest ratio; keep CNT_W at 23 or more
   assign at_last = (count == last_count(prescale_select));
   // A ratio change or clear restarts the interval from zero
   assign restart = reset_i || !run || wdt_clear_i || ctrl_write;

   always @* begin
      next_count   = count + {{(CNT_W-1){1'b0}}, 1'b1};
      next_timeout = 1'b0;
      if (restart) begin
         next_count   = {CNT_W{1'b0}};
         next_timeout = 1'b0;
      end else if (at_last) begin
         next_count   = {CNT_W{1'b0}};
         next_timeout = 1'b1;
      end
   end

   always @(posedge mclk_i) begin
      count <= next_count;
   end

   always @(posedge mclk_i) begin
      wdt_timeout_o <= next_timeout;
   end

   // ************************************************************
   // Read port
   // ************************************************************
   always @* begin
      next_rdata = `WDC_UNMAPPED_READ;
      if (ctrl_read) begin
         next_rdata = {2'b00, prescale_select, soft_enable};
      end else if (count_read) begin
         // Only the top byte of the counter is visible
         next_rdata = count[CNT_W-1:CNT_W-8];
      end
   end

   // Read data stand for one cycle only
   always @(posedge mclk_i) begin
      if (reset_i) begin
         rdata_o <= `WDC_RDATA_RST;
      end else begin
         rdata_o <= next_rdata;
      end
   end

   // ************************************************************
   // Status outputs
   // ************************************************************
   // Registered copies lag the live state by one cycle
   always @(posedge mclk_i) begin
      if (reset_i) begin
         wdt_running_o <= 1'b0;
      end else begin
         wdt_running_o <= run;
      end
   end

   always @(posedge mclk_i) begin
      if (reset_i) begin
         prescale_select_o <= `WDC_PS_OUT_RST;
      end else begin
         prescale_select_o <= prescale_select;
      end
   end

endmodule

`default_nettype wire

/* File: inc/wdc_regs.vh */
`ifndef WDC_REGS_VH
`define WDC_REGS_VH

// ************************************************************
// Register map
// ************************************************************
`define WDC_CTRL_ZERO_ADDR  4'h0
`define WDC_COUNT_ADDR      4'h1
`define WDC_SOFT_EN_BIT     0
`define WDC_PS_LSB          1
`define WDC_PS_MSB          5

// ************************************************************
// Prescale codes and reset values
// ************************************************************
`define WDC_PS_MAX_CODE     5'h12
`define WDC_PS_ALL_ONES     5'h1f
`define WDC_PS_FORCED_RST   5'h0b
`define WDC_PS_BASE_LOG2    5'h05
`define WDC_SOFT_EN_RST     1'h0
`define WDC_RDATA_RST       8'h00
`define WDC_UNMAPPED_READ   8'h00
`define WDC_PS_OUT_RST      5'h00

// ************************************************************
// Enable modes
// ************************************************************
`define WDC_MODE_OFF        2'h0
`define WDC_MODE_SOFT       2'h1
`define WDC_MODE_SLEEP_OFF  2'h2
`define WDC_MODE_ON         2'h3

`endif

/* File: tb/wdc_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module wdc_checker (
   // Clock and reset
   input wire logic       mclk_i,
   input wire logic       reset_i,
   // Configuration and register port
   input wire logic [4:0] config_prescale_default_i,
   input wire logic [1:0] config_enable_mode_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   // Outputs watched
   input wire logic [7:0] rdata_o,
   input wire logic       wdt_running_o,
   input wire logic       wdt_timeout_o,
   input wire logic [4:0] prescale_select_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   sequence s_ctrl_read;
      rd_i && addr_i == 4'h0;
   endsequence
   sequence s_soft_stop;
      config_enable_mode_i == 2'h1 && wr_i && addr_i == 4'h0 &&
         !wdata_i[0];
   endsequence
   property p_ctrl_rd; s_ctrl_read
      |=> rdata_o[7:1] == {2'b00, prescale_select_o}; endproperty
   property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
   property p_pulse; wdt_timeout_o |=> !wdt_timeout_o; endproperty
   property p_stop; !wdt_running_o |-> !wdt_timeout_o; endproperty
   property p_soft_off; s_soft_stop |=> ##1 !wdt_running_o;
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl read");
   a_rd_idle: assert property (p_rd_idle) else $error("rdata held");
   a_pulse: assert property (p_pulse) else $error("long pulse");
   a_stop: assert property (p_stop) else $error("idle tmo");
   a_soft_off: assert property (p_soft_off) else $error("soft");
   property p_dflt; config_prescale_default_i == 5'h1f && $fell(reset_i)
      |=> prescale_select_o == 5'h0b; endproperty
   property p_cfg; config_prescale_default_i != 5'h1f && !$past(reset_i)
      |-> prescale_select_o == config_prescale_default_i; endproperty
   a_dflt: assert property (p_dflt) else $error("bad reset");
   a_cfg: assert property (p_cfg) else $error("moved");
endmodule
bind wdc_prescale_control wdc_checker u_chk (.mclk_i(mclk_i),
   .reset_i(reset_i), .prescale_select_o(prescale_select_o),
   .config_prescale_default_i(config_prescale_default_i),
   .config_enable_mode_i(config_enable_mode_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .wdt_running_o(wdt_running_o), .wdt_timeout_o(wdt_timeout_o));
`default_nettype wire

/* File: tb/wdc_prescale_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module wdc_prescale_control_tb;
   logic clk = 0, rst = 1, wr = 0, rd = 0, run, tmo, slp = 0, clr = 0;
   logic [1:0] mode = 2'h1;
   logic [4:0] cfg = 5'h1f, psel;
   logic [3:0] adr = 4'h0;
   logic [7:0] wd = 8'h00, rdat;
   int miscompares = 0, checks = 0, cyc = 0, n;
   always #2 clk = ~clk;
   wdc_prescale_control u_dut (.mclk_i(clk), .reset_i(rst), .addr_i(adr),
      .config_prescale_default_i(cfg), .config_enable_mode_i(mode),
      .sleep_i(slp), .wdt_clear_i(clr), .wdata_i(wd), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdat), .wdt_running_o(run), .wdt_timeout_o(tmo),
      .prescale_select_o(psel));
   task chk(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) miscompares++;
      if (g !== e) $display("[FAIL] %0t got %h want %h", $time, g, e);
   endtask
   task io(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      {wr, rd, adr, wd} <= {w, !w, a, d};
      @(posedge clk);
      {wr, rd} <= 2'b00;
      #1 if (!w) chk(rdat, d);
   endtask
   // Gap in cycles between two consecutive time-out pulses
   task period(input logic [4:0] code, output int p);
      io(1, 4'h0, {2'b00, code, 1'b1});
      p = 0;
      while (!tmo && p < 300) begin
         @(posedge clk);
         #1 p++;
      end
      p = 0;
      do begin
         @(posedge clk);
         #1 p++;
      end while (!tmo && p < 300);
   endtask
   task runchk(input logic e);
      repeat (2) @(posedge clk);
      #1 chk({7'h00, run}, {7'h00, e});
   endtask
   task conclude;
      miscompares += (cyc >= 2000);
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) if (++cyc == 2000) conclude;
   initial begin
      repeat (8) @(posedge clk);
      rst <= 0;
      io(0, 4'h0, 8'h16);
      chk({3'h0, psel}, 8'h0b);
      io(1, 4'h0, 8'h25);
      io(0, 4'h0, 8'h25);
      chk({7'h00, run}, 8'h01);
      chk({3'h0, psel}, 8'h12);
      period(5'h00, n);
      chk(n[7:0], 8'h20);
      period(5'h01, n);
      chk(n[7:0], 8'h40);
      period(5'h13, n);
      chk(n[7:0], 8'h20);
      period(5'h1f, n);
      chk(n[7:0], 8'h20);
      @(posedge clk);
      mode <= 2'h0;
      runchk(1'b0);
      @(posedge clk);
      mode <= 2'h3;
      runchk(1'b1);
      @(posedge clk);
      {mode, slp} <= {2'h2, 1'b1};
      runchk(1'b0);
      @(posedge clk);
      {mode, slp} <= {2'h1, 1'b0};
      io(1, 4'h0, 8'h00);
      runchk(1'b0);
      io(0, 4'h2, 8'h00);
      @(posedge clk);
      {rst, cfg} <= {1'b1, 5'h07};
      repeat (8) @(posedge clk);
      rst <= 0;
      io(0, 4'h0, 8'h0e);
      io(1, 4'h0, 8'h3f);
      io(0, 4'h0, 8'h0f);
      chk({3'h0, psel}, 8'h07);
      conclude;
   end
endmodule
`default_nettype wire
